// [hdl/hvw_pkg.sv]
// package for the high-voltage wake input block: map, fields, modes, timing
package hvw_pkg;

    // =====================================================================
    // geometry and timing
    localparam int unsigned N_PINS      = 4;
    localparam int unsigned CLK_MHZ     = 100;
    localparam int unsigned FILT1_US    = 16;
    localparam int unsigned FILT2_US    = 64;
    localparam int unsigned FILT1_CYC   = FILT1_US * CLK_MHZ;
    localparam int unsigned FILT2_CYC   = FILT2_US * CLK_MHZ;
    localparam int unsigned CNT_W       = 16;

    // =====================================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL0    = 8'h00;  // control of pin i at OFS_CTRL0 + 4*i
    localparam logic [7:0] OFS_MODE     = 8'h10;
    localparam logic [7:0] OFS_STAT     = 8'h14;
    localparam logic [7:0] OFS_LVL      = 8'h18;
    localparam logic [7:0] OFS_MASK     = 8'h1C;

    // =====================================================================
    // control field positions and codes
    localparam int unsigned CTL_FILT_LSB = 0;
    localparam int unsigned CTL_PULL_LSB = 3;
    localparam int unsigned CTL_EN_LSB   = 5;
    localparam int unsigned CTL_W        = 7;

    localparam logic [1:0] EN_OFF       = 2'h0;
    localparam logic [1:0] EN_WAKE      = 2'h1;
    localparam logic [1:0] EN_SYNC      = 2'h2;

    localparam logic [1:0] PULL_NONE    = 2'h0;
    localparam logic [1:0] PULL_DOWN    = 2'h1;
    localparam logic [1:0] PULL_UP      = 2'h2;
    localparam logic [1:0] PULL_AUTO    = 2'h3;

    localparam logic [2:0] FILT_ST1     = 3'h0;  // static, first filter time
    localparam logic [2:0] FILT_ST2     = 3'h1;  // static, second filter time
    localparam logic [2:0] FILT_CY1     = 3'h2;  // cyclic, window from high-side switch
    localparam logic [2:0] FILT_CY2     = 3'h3;
    localparam logic [2:0] FILT_CYSYNC  = 3'h4;  // cyclic with synchronization

    localparam logic [N_PINS*CTL_W-1:0] CTRL_RST = '0;

    // =====================================================================
    // types
    typedef struct packed {
        logic [1:0] wake_enable_select;
        logic [1:0] pull_select;       // [1] pull_select_high_bit, [0] pull_select_low_bit
        logic [2:0] wake_filter_select;
    } hvw_ctrl_t;

    typedef enum logic [2:0] {
        MD_INIT     = 3'b000,
        MD_NORMAL   = 3'b001,
        MD_STOP     = 3'b010,
        MD_SLEEP    = 3'b011,
        MD_FAILSAFE = 3'b100,
        MD_RESTART  = 3'b101
    } hvw_mode_t;

    typedef struct packed {
        logic [N_PINS-1:0] up;
        logic [N_PINS-1:0] down;
    } hvw_pull_t;

endpackage

// [hdl/hvw_wake_input.sv]
// high-voltage wake input block with AHB-Lite register slave
// Notes on behaviour
// - every wake pin flags an event on both rising and falling level changes.
// - events raise interrupt in Normal/Stop, wake the device in Sleep/Fail-Safe.
// - software picks static sense (always watched) or cyclic sense (watched in window).
// - a threshold crossing starts the filter; recrossing before expiry cancels the wake.
// - each pin's wake capability is enabled or disabled by software.
// - every pin wake event sets a sticky bit in the wake event status.
// - pin levels readable in Normal/Stop/Init; cyclic sense shows last sampled level.
// - pull select 00 none (reset), 01 pull-down, 10 pull-up.
// - pull select 11 follows the level: pull-up when high, pull-down when low.
// - each pin has a filter select for static and cyclic sensing.
// - Init to Normal in static sense with pin high sets status and interrupt.
// - cyclic sense samples during high-side switch on-time; a change is an event.
// - enable field 10 makes the fourth pin the sync input with no wake.
// - Sleep request refused, Restart entered, when only wake source is cyclic sync.
// - the fourth pin level is not reported while it serves as sync input.
// - first filter time is 16 us.
// - second filter time is 64 us.
`timescale 1ns/1ns
module hvw_wake_input
    import hvw_pkg::*;
#(
    parameter int unsigned FILT1_CYCLES = hvw_pkg::FILT1_CYC,   // first filter, cycles
    parameter int unsigned FILT2_CYCLES = hvw_pkg::FILT2_CYC    // second filter, cycles
) (
    input  wire logic                       core_clk,       // 100 MHz clock
    input  wire logic                       rst_n,          // async reset, active low
    input  wire logic                       hsel,           // AHB-Lite select
    input  wire logic [31:0]                haddr,          // byte address
    input  wire logic [1:0]                 htrans,         // transfer type
    input  wire logic                       hwrite,         // write strobe
    input  wire logic [2:0]                 hsize,          // transfer size
    input  wire logic [31:0]                hwdata,         // write data
    input  wire logic                       hready,         // bus ready in
    output logic [31:0]                     hrdata,         // read data
    output logic                            hreadyout,      // slave ready
    output logic                            hresp,          // always OKAY
    input  wire logic [hvw_pkg::N_PINS-1:0] wake_input_pin, // comparator outputs
    input  wire logic [hvw_pkg::N_PINS-1:0] hs_on,          // high-side switch on-times
    output hvw_pkg::hvw_pull_t              pull_en,        // current source enables
    output logic                            sync_out,       // sync level toward switches
    output logic [2:0]                      dev_mode,       // present device mode
    output logic                            wake_req,       // wake from low-power mode
    output logic                            irq             // level interrupt
);
    import hvw_pkg::*;

    localparam int unsigned LAST = N_PINS - 1;

    // =====================================================================
    // registers and state
    logic [N_PINS*CTL_W-1:0] ctrl_ff;
    logic [N_PINS-1:0]       stat_ff;
    logic [N_PINS-1:0]       mask_ff;
    logic [N_PINS-1:0]       lvl_ff;
    hvw_mode_t               mode_ff;
    logic                    nrm_entry_ff;
    logic                    wake_req_ff;
    logic                    irq_ff;
    logic                    sync_out_ff;
    hvw_pull_t               pull_ff;
    logic                    wr_pend_ff;
    logic [7:0]              wr_addr_ff;
    logic                    rd_pend_ff;
    logic [7:0]              rd_addr_ff;
    logic [31:0]             hrdata_ff;
    logic                    hreadyout_ff;

    logic [N_PINS-1:0]       pin_lvl;     // synchronised pin levels
    logic [N_PINS-1:0]       pin_acc;     // filtered or sampled levels
    logic [N_PINS-1:0]       pin_evt;     // one-cycle wake events
    logic [N_PINS-1:0]       pin_act;     // pin takes part in wake detection
    logic [N_PINS-1:0]       pin_cyc;     // pin in cyclic sense
    logic                    sync_mode;
    logic                    refuse_sleep;
    logic [N_PINS-1:0]       entry_set;
    logic [2*N_PINS-1:0]     psel;

    function automatic hvw_ctrl_t ctl_of(input logic [N_PINS*CTL_W-1:0] v, input int unsigned i);
        ctl_of = v[i*CTL_W +: CTL_W];
    endfunction

    function automatic logic is_cyclic(input logic [2:0] f);
        is_cyclic = (f == FILT_CY1) || (f == FILT_CY2) || (f == FILT_CYSYNC);
    endfunction

    // the fourth pin leaves wake duty entirely while it is the sync input
    assign sync_mode = (ctl_of(ctrl_ff, LAST).wake_enable_select == EN_SYNC);

    // =====================================================================
    // per-pin detection
    genvar gi;
    generate
        for (gi = 0; gi < N_PINS; gi++) begin : g_pin
            logic             s1_ff;
            logic             s2_ff;
            logic             acc_ff;
            logic [CNT_W-1:0] cnt_ff;
            logic             win_ff;
            logic             evt_ff;
            hvw_ctrl_t        c;
            logic [CNT_W-1:0] limit;
            logic             win;
            logic             ignored;

            assign c       = ctl_of(ctrl_ff, gi);
            assign ignored = (gi == LAST) && sync_mode;
            // filter select chooses the qualification time
            assign limit   = (c.wake_filter_select == FILT_ST2 ||
                              c.wake_filter_select == FILT_CY2) ?
                             CNT_W'(FILT2_CYCLES - 1) : CNT_W'(FILT1_CYCLES - 1);
            // with sync the sense window follows the fourth pin, else the switch on-time
            assign win     = (c.wake_filter_select == FILT_CYSYNC) ? g_pin[LAST].s2_ff
                                                                    : hs_on[gi];

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                end else begin
                    s1_ff <= wake_input_pin[gi];
                    s2_ff <= s1_ff;
                end
            end

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    acc_ff <= 1'b0;
                    cnt_ff <= '0;
                    win_ff <= 1'b0;
                    evt_ff <= 1'b0;
                end else begin
                    win_ff <= win;
                    evt_ff <= 1'b0;
                    if (ignored) begin
                        cnt_ff <= '0;
                        acc_ff <= s2_ff;
                    end else if (is_cyclic(c.wake_filter_select)) begin
                        cnt_ff <= '0;
                        // sample taken at the end of the on-time, when the pin has settled
                        if (win_ff && !win) begin
                            acc_ff <= s2_ff;
                            evt_ff <= (s2_ff != acc_ff);
                        end
                    end else if (s2_ff != acc_ff) begin
                        if (cnt_ff >= limit) begin
                            acc_ff <= s2_ff;
                            cnt_ff <= '0;
                            evt_ff <= 1'b1;
                        end else begin
                            cnt_ff <= cnt_ff + CNT_W'(1);
                        end
                    end else begin
                        cnt_ff <= '0;
                    end
                end
            end

            assign pin_lvl[gi] = s2_ff;
            assign pin_acc[gi] = acc_ff;
            assign psel[2*gi +: 2] = c.pull_select;
            assign pin_cyc[gi] = is_cyclic(c.wake_filter_select);
            assign pin_act[gi] = !ignored && (c.wake_enable_select == EN_WAKE ||
                                              (c.wake_enable_select == EN_SYNC && gi != LAST) ||
                                              c.wake_enable_select == 2'h3);
            assign pin_evt[gi] = evt_ff && pin_act[gi];
            assign entry_set[gi] = nrm_entry_ff && pin_act[gi] && !pin_cyc[gi] && s2_ff;
        end
    endgenerate

    // sleep is pointless if only sync-driven sensing could wake: its driver is unpowered
    always_comb begin
        refuse_sleep = 1'b0;
        if (|pin_act) begin
            refuse_sleep = 1'b1;
            for (int i = 0; i < N_PINS; i++) begin
                if (pin_act[i] && ctl_of(ctrl_ff, i).wake_filter_select != FILT_CYSYNC) begin
                    refuse_sleep = 1'b0;
                end
            end
        end
    end

    // =====================================================================
    // AHB-Lite slave: writes take no wait, reads take one so a just-written value is seen
    logic addr_ok;
    assign addr_ok = hsel && htrans[1] && hready;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_ff   <= 1'b0;
            wr_addr_ff   <= 8'h00;
            rd_pend_ff   <= 1'b0;
            rd_addr_ff   <= 8'h00;
            hreadyout_ff <= 1'b1;
        end else begin
            wr_pend_ff   <= addr_ok && hwrite;
            rd_pend_ff   <= addr_ok && !hwrite;
            hreadyout_ff <= !(addr_ok && !hwrite);
            if (addr_ok) begin
                wr_addr_ff <= haddr[7:0];
                rd_addr_ff <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rd_pend_ff) begin
            hrdata_ff <= 32'h0000_0000;
            for (int i = 0; i < N_PINS; i++) begin
                if (rd_addr_ff == OFS_CTRL0 + 8'(4 * i)) begin
                    hrdata_ff[CTL_W-1:0] <= ctrl_ff[i*CTL_W +: CTL_W];
                end
            end
            unique case (rd_addr_ff)
                OFS_MODE: hrdata_ff[2:0]        <= mode_ff;
                OFS_STAT: hrdata_ff[N_PINS-1:0] <= stat_ff;
                OFS_LVL:  hrdata_ff[N_PINS-1:0] <= lvl_ff;
                OFS_MASK: hrdata_ff[N_PINS-1:0] <= mask_ff;
                default:  ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= CTRL_RST;
            mask_ff <= '0;
        end else if (wr_pend_ff) begin
            for (int i = 0; i < N_PINS; i++) begin
                if (wr_addr_ff == OFS_CTRL0 + 8'(4 * i)) begin
                    ctrl_ff[i*CTL_W +: CTL_W] <= hwdata[CTL_W-1:0];
                end
            end
            if (wr_addr_ff == OFS_MASK) begin
                mask_ff <= hwdata[N_PINS-1:0];
            end
        end
    end

    // =====================================================================
    // device mode
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff      <= MD_INIT;
            nrm_entry_ff <= 1'b0;
        end else begin
            nrm_entry_ff <= 1'b0;
            if (wr_pend_ff && wr_addr_ff == OFS_MODE) begin
                unique case (hwdata[2:0])
                    MD_NORMAL: begin
                        mode_ff      <= MD_NORMAL;
                        nrm_entry_ff <= (mode_ff == MD_INIT);
                    end
                    MD_STOP:     mode_ff <= MD_STOP;
                    MD_SLEEP:    mode_ff <= refuse_sleep ? MD_RESTART : MD_SLEEP;
                    MD_FAILSAFE: mode_ff <= MD_FAILSAFE;
                    MD_RESTART:  mode_ff <= MD_RESTART;
                    MD_INIT:     mode_ff <= MD_INIT;
                    default:     ;
                endcase
            end
        end
    end

    // =====================================================================
    // status, level, interrupt and wake
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_ff <= '0;
        end else begin
            // a new event in the clearing cycle survives: set wins over clear
            stat_ff <= (stat_ff & ~((wr_pend_ff && wr_addr_ff == OFS_STAT) ?
                                    hwdata[N_PINS-1:0] : '0))
                       | pin_evt | entry_set;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_ff <= '0;
        end else if (mode_ff == MD_NORMAL || mode_ff == MD_STOP || mode_ff == MD_INIT) begin
            for (int i = 0; i < N_PINS; i++) begin
                lvl_ff[i] <= pin_cyc[i] ? pin_acc[i] : pin_lvl[i];
            end
            if (sync_mode) begin
                lvl_ff[LAST] <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff      <= 1'b0;
            wake_req_ff <= 1'b0;
        end else begin
            irq_ff <= (mode_ff == MD_NORMAL || mode_ff == MD_STOP) && |(stat_ff & mask_ff);
            if (wr_pend_ff && wr_addr_ff == OFS_MODE) begin
                wake_req_ff <= 1'b0;
            end else if ((mode_ff == MD_SLEEP || mode_ff == MD_FAILSAFE) && |pin_evt) begin
                wake_req_ff <= 1'b1;
            end
        end
    end

    // =====================================================================
    // pull sources and sync output
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pull_ff     <= '0;
            sync_out_ff <= 1'b0;
        end else begin
            sync_out_ff <= sync_mode && pin_lvl[LAST];
            for (int i = 0; i < N_PINS; i++) begin
                pull_ff.up[i]   <= (psel[2*i +: 2] == PULL_UP) ||
                                   (psel[2*i +: 2] == PULL_AUTO && pin_lvl[i]);
                pull_ff.down[i] <= (psel[2*i +: 2] == PULL_DOWN) ||
                                   (psel[2*i +: 2] == PULL_AUTO && !pin_lvl[i]);
            end
            if (sync_mode) begin
                pull_ff.up[LAST]   <= 1'b0;
                pull_ff.down[LAST] <= 1'b0;
            end
        end
    end

    assign hrdata    = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp     = 1'b0;
    assign pull_en   = pull_ff;
    assign sync_out  = sync_out_ff;
    assign dev_mode  = mode_ff;
    assign wake_req  = wake_req_ff;
    assign irq       = irq_ff;

endmodule

// [dv/hvw_pin_src.sv]
// far-side model: external switches or signal lines on the wake pins
`timescale 1ns/1ns
module hvw_pin_src
    import hvw_pkg::*;
(
    input  wire logic                  core_clk, // paces the open-pin pattern
    input  wire hvw_pkg::hvw_pull_t    pull_en,  // current sources of the block
    output logic [hvw_pkg::N_PINS-1:0] pin       // levels at the comparators
);
    // ==========
    // drive state
    logic [N_PINS-1:0] drv_en_ff;
    logic [N_PINS-1:0] drv_val_ff;
    logic              noise_ff;

    initial begin
        drv_en_ff = '1;
        drv_val_ff = '0;
        noise_ff = 1'b0;
    end

    always @(posedge core_clk) begin
        noise_ff <= ~noise_ff;
    end

    // an open pin with no current source never holds a level
    always_comb begin
        for (int i = 0; i < N_PINS; i++) begin
            pin[i] = drv_en_ff[i] ? drv_val_ff[i] :
                     pull_en.up[i] ? 1'b1 : pull_en.down[i] ? 1'b0 : noise_ff;
        end
    end

    // ==========
    // bench controls
    task automatic drive(input int p, input logic v);
        drv_en_ff[p] <= 1'b1;
        drv_val_ff[p] <= v;
    endtask

    task automatic open_pin(input int p);
        drv_en_ff[p] <= 1'b0;
    endtask
endmodule

// [dv/hvw_wake_input_chk.sv]
// port-level assertions for the wake input block
`timescale 1ns/1ns
module hvw_wake_input_chk
    import hvw_pkg::*;
(
    input wire logic                       core_clk,       // clock
    input wire logic                       rst_n,          // reset
    input wire logic                       hsel,           // select
    input wire logic [1:0]                 htrans,         // transfer type
    input wire logic                       hwrite,         // write
    input wire logic                       hready,         // bus ready
    input wire logic                       hreadyout,      // slave ready
    input wire logic                       hresp,          // response
    input wire logic [hvw_pkg::N_PINS-1:0] wake_input_pin, // pins
    input wire hvw_pkg::hvw_pull_t         pull_en,        // pulls
    input wire logic                       sync_out,       // sync level
    input wire logic [2:0]                 dev_mode,       // mode
    input wire logic                       wake_req,       // wake
    input wire logic                       irq             // interrupt
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ==========
    // high through each write data phase
    logic wr_dp_ff;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_dp_ff <= 1'b0;
        end else begin
            wr_dp_ff <= hsel & htrans[1] & hready & hwrite;
        end
    end

    // ==========
    // assertions
    AST_IRQ_MODE: assert property (irq |-> dev_mode inside {MD_NORMAL, MD_STOP} ||
        $past(dev_mode) inside {MD_NORMAL, MD_STOP}) else $error("irq in wrong mode");
    AST_WAKE_MODE: assert property ($rose(wake_req) |->
        dev_mode inside {MD_SLEEP, MD_FAILSAFE}) else $error("wake in wrong mode");
    AST_WAKE_HOLD: assert property ($fell(wake_req) |->
        $past(wr_dp_ff) || $past(wr_dp_ff, 2)) else $error("wake dropped early");
    AST_IRQ_STICKY: assert property ($fell(irq) |-> $past(wr_dp_ff) || $past(wr_dp_ff, 2) ||
        $past(wr_dp_ff, 3)) else $error("irq dropped early");
    AST_MODE_SW: assert property (dev_mode != $past(dev_mode) |-> $past(wr_dp_ff))
        else $error("mode changed alone");
    AST_PULL_EXCL: assert property ((pull_en.up & pull_en.down) == '0)
        else $error("both pulls on");
    AST_SYNC_PULL: assert property (sync_out |->
        !pull_en.up[3] && !pull_en.down[3]) else $error("pull on sync pin");
    AST_SYNC_FOLLOW: assert property (sync_out |-> $past(wake_input_pin[3], 2) ||
        $past(wake_input_pin[3], 3)) else $error("sync without pin");
    AST_READ_WAIT: assert property (hsel && htrans[1] && hready && !hwrite |=>
        !hreadyout ##1 hreadyout && !hresp) else $error("read wait wrong");
endmodule

// [dv/tb_top.sv]
// self-checking bench for the wake input block
`timescale 1ns/1ns
module tb_top;
    import hvw_pkg::*;
    localparam int F1 = 8;   // short filter counts keep the run brief
    localparam int F2 = 20;

    typedef struct packed {
        logic [1:0] pull;
        logic       drv, lvl, up, dn;
    } hvw_row_t;

    logic              core_clk, rst_n, hsel, hwrite, hreadyout, hresp;
    logic              sync_out, wake_req, irq;
    logic [31:0]       haddr, hwdata, hrdata, rd;
    logic [1:0]        htrans;
    logic [2:0]        hsize, dev_mode;
    logic [N_PINS-1:0] pin, hs_on;
    hvw_pull_t         pull_en;
    int                n_mismatch, checks_done;
    hvw_row_t          rows [5] = '{
        '{PULL_NONE, 1'b1, 1'b1, 1'b0, 1'b0}, '{PULL_DOWN, 1'b0, 1'b0, 1'b0, 1'b1},
        '{PULL_UP, 1'b0, 1'b1, 1'b1, 1'b0}, '{PULL_AUTO, 1'b1, 1'b1, 1'b1, 1'b0},
        '{PULL_AUTO, 1'b1, 1'b0, 1'b0, 1'b1}};

    hvw_wake_input #(.FILT1_CYCLES(F1), .FILT2_CYCLES(F2)) i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wake_input_pin(pin),
        .hs_on(hs_on), .pull_en(pull_en), .sync_out(sync_out), .dev_mode(dev_mode),
        .wake_req(wake_req), .irq(irq));
    hvw_pin_src i_src (.core_clk(core_clk), .pull_en(pull_en), .pin(pin));

    always #5 core_clk = ~core_clk;

    // ==========
    // tasks
    task automatic wrap_up();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wait_rdy();
        int n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] en, input logic [1:0] pl,
                                        input logic [2:0] ft);
        return {25'h0, en, pl, ft};
    endfunction

    // ==========
    // sequence
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        {hsel, haddr, htrans, hwrite, hwdata, hs_on} = '0;
        hsize = 3'h2;
        n_mismatch = 0;
        checks_done = 0;
        cyc(5);
        rst_n <= 1'b1;
        cyc(1);
        chk({pull_en, sync_out, dev_mode, wake_req, irq, hresp}, 32'h0);
        for (int a = 0; a < 32; a += 4) rdc(8'(a), 32'h0);
        wr(8'h40, 32'hFFFF_FFFF);
        rdc(8'h40, 32'h0);
        foreach (rows[i]) begin
            wr(OFS_CTRL0, ctl(EN_WAKE, rows[i].pull, FILT_ST1));
            if (rows[i].drv) i_src.drive(0, rows[i].lvl);
            else i_src.open_pin(0);
            cyc(8);
            chk({30'h0, pull_en.up[0], pull_en.down[0]}, {30'h0, rows[i].up, rows[i].dn});
            rdc(OFS_LVL, {31'h0, rows[i].lvl});
        end
        wr(OFS_CTRL0, ctl(EN_WAKE, PULL_NONE, FILT_ST1));
        i_src.drive(0, 1'b0);
        cyc(F2 + 10);
        wr(OFS_STAT, 32'h0000_000F);
        wr(OFS_MASK, 32'h0000_0001);
        wr(OFS_MODE, {29'h0, MD_NORMAL});
        i_src.drive(0, 1'b1);
        cyc(F1 / 2);
        i_src.drive(0, 1'b0);
        cyc(F1 + 8);
        rdc(OFS_STAT, 32'h0);
        i_src.drive(0, 1'b1);
        cyc(F1 - 3);
        rdc(OFS_STAT, 32'h0);
        cyc(10);
        rdc(OFS_STAT, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_STAT, 32'h1);
        cyc(4);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_MODE, 32'(MD_STOP));
        wr(OFS_MASK, 32'h0);
        i_src.drive(0, 1'b0);
        cyc(F1 + 8);
        rdc(OFS_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_MASK, 32'h1);
        cyc(4);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_STAT, 32'h1);
        wr(OFS_CTRL0, ctl(EN_WAKE, PULL_NONE, FILT_ST2));
        i_src.drive(0, 1'b1);
        cyc(F1 + 4);
        rdc(OFS_STAT, 32'h0);
        cyc(F2);
        rdc(OFS_STAT, 32'h1);
        rdc(OFS_LVL, 32'h1);
        wr(OFS_STAT, 32'h1);
        i_src.drive(1, 1'b1);
        cyc(F2 + 8);
        rdc(OFS_STAT, 32'h0);
        i_src.drive(1, 1'b0);
        wr(OFS_MODE, {29'h0, MD_SLEEP});
        i_src.drive(0, 1'b0);
        cyc(F2 + 8);
        chk({27'h0, dev_mode, wake_req, irq}, {27'h0, MD_SLEEP, 2'b10});
        rdc(OFS_STAT, 32'h1);
        wr(OFS_STAT, 32'h1);
        wr(OFS_MODE, {29'h0, MD_NORMAL});
        cyc(2);
        chk({31'h0, wake_req}, 32'h0);
        wr(OFS_CTRL0 + 8'h08, ctl(EN_WAKE, PULL_NONE, FILT_CY1));
        i_src.drive(2, 1'b1);
        cyc(10);
        rdc(OFS_STAT, 32'h0);
        rdc(OFS_LVL, 32'h0);
        hs_on[2] <= 1'b1;
        cyc(3);
        hs_on[2] <= 1'b0;
        cyc(6);
        rdc(OFS_STAT, 32'h4);
        i_src.drive(2, 1'b0);
        cyc(6);
        rdc(OFS_LVL, 32'h4);
        wr(OFS_STAT, 32'h4);
        wr(OFS_CTRL0 + 8'h0C, ctl(EN_OFF, PULL_NONE, FILT_ST1));
        wr(OFS_CTRL0 + 8'h0C, ctl(EN_SYNC, PULL_UP, FILT_ST1));
        i_src.drive(3, 1'b1);
        cyc(F1 + 8);
        chk({29'h0, sync_out, pull_en.up[3], pull_en.down[3]}, 32'h4);
        rdc(OFS_STAT, 32'h0);
        rdc(OFS_LVL, 32'h4);
        i_src.drive(3, 1'b0);
        cyc(6);
        chk({31'h0, sync_out}, 32'h0);
        wr(OFS_CTRL0 + 8'h0C, 32'h0);
        wr(OFS_CTRL0 + 8'h08, 32'h0);
        wr(OFS_CTRL0, ctl(EN_WAKE, PULL_NONE, FILT_CYSYNC));
        wr(OFS_MODE, {29'h0, MD_SLEEP});
        rdc(OFS_MODE, {29'h0, MD_RESTART});
        i_src.drive(0, 1'b1);
        rst_n <= 1'b0;
        cyc(3);
        rst_n <= 1'b1;
        cyc(F2 + 10);
        wr(OFS_CTRL0, ctl(EN_WAKE, PULL_NONE, FILT_ST1));
        wr(OFS_MASK, 32'h1);
        wr(OFS_MODE, {29'h0, MD_NORMAL});
        cyc(2);
        rdc(OFS_STAT, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wrap_up();
    end
endmodule

bind hvw_wake_input hvw_wake_input_chk i_chk (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .wake_input_pin(wake_input_pin),
    .pull_en(pull_en), .sync_out(sync_out), .dev_mode(dev_mode), .wake_req(wake_req),
    .irq(irq)
);
